// ---- rtl/pll_ctl_pkg.sv ----
/*
 * Shared constants for the reference switchover and scan-chain
 * reconfiguration controller.
 * Assumes a single 40 MHz system clock; all pins arrive asynchronously.
 */
package pll_ctl_pkg;
    localparam int  CLK_MHZ           = 40;
    localparam int  SWITCH_HOLD_CYC   = 3;   // rising edges of either reference the request must stay high for
    localparam int  LOSS_TIMEOUT_CYC  = 64;  // system cycles without a reference edge = lost
    localparam int  CHAIN_LEN_TEN     = 234; // ten-counter variant
    localparam int  CHAIN_LEN_SEVEN   = 180; // seven-counter variant
    localparam int  APPLY_CYC         = 4;   // unused; the copy-in phase lasts until every bit has seen its counter tick
    localparam int  CNT_W             = 8;
    localparam logic SEL_PRIMARY      = 1'b0;
    localparam logic SEL_BACKUP       = 1'b1;

    // switchover sequence states
    typedef enum logic [3:0] {
        SW_IDLE     = 4'b0001,
        SW_GATE_OLD = 4'b0010,
        SW_WAIT_NEW = 4'b0100,
        SW_HOLD     = 4'b1000
    } sw_state_t;
endpackage

// ---- rtl/ref_edge_sense.sv ----
/*
 * Reference clock sense: synchronises one reference input, reports rising
 * and falling edges, counts system cycles since the last edge and flags a stopped clock.
 * Assumes the reference is slower than half the system clock.
 */
`timescale 1ns/1ps
module ref_edge_sense #(
    parameter int TIMEOUT = pll_ctl_pkg::LOSS_TIMEOUT_CYC
) (
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_ref,
    output logic      o_rise,
    output logic      o_fall,
    output logic      o_lost
);
    logic       meta;
    logic       sync;
    logic       prev;
    logic [7:0] idle_cnt;
    logic [7:0] next_idle_cnt;
    logic       next_lost;
    logic       lost;

    // edge detect on the second stage only
    assign o_rise = sync & ~prev;
    assign o_fall = ~sync & prev;
    assign o_lost = lost;

    // inactivity counter: any edge restarts it
    always_comb begin
        next_idle_cnt = idle_cnt;
        next_lost     = lost;
        if (o_rise || o_fall) begin
            next_idle_cnt = 8'h00;
            next_lost     = 1'b0;
        end else if (idle_cnt == 8'(TIMEOUT)) begin
            next_lost = 1'b1;
        end else begin
            next_idle_cnt = idle_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            meta     <= 1'b0;
            sync     <= 1'b0;
            prev     <= 1'b0;
            idle_cnt <= 8'h00;
            lost     <= 1'b0;
        end else begin
            meta     <= i_ref;
            sync     <= meta;
            prev     <= sync;
            idle_cnt <= next_idle_cnt;
            lost     <= next_lost;
        end
    end
endmodule // ref_edge_sense

// ---- rtl/pll_switchover_and_reconfig.sv ----
/*
 * Reference switchover sequencer and reconfiguration scan chain.
 * Assumes all pins are asynchronous to i_mclk; the shift clock is sampled
 * and its rising edges found, so it must run below half of 40 MHz.
 */
`timescale 1ns/1ps
module pll_switchover_and_reconfig #(
    parameter int CHAIN_LEN = pll_ctl_pkg::CHAIN_LEN_TEN,
    parameter int HOLD_CYC  = pll_ctl_pkg::SWITCH_HOLD_CYC
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ref_clock_primary,
    input  wire logic                 i_ref_clock_backup,
    input  wire logic                 i_switch_req,
    input  wire logic                 i_auto_mode,
    input  wire logic                 i_scan_clk,
    input  wire logic                 i_scan_data,
    input  wire logic                 i_scan_ena,
    input  wire logic                 i_apply,
    input  wire logic [CHAIN_LEN-1:0] i_counter_clk_tick,
    output logic                      o_ref_mux_sel,
    output logic                      o_ref_gate_ena,
    output logic                      o_active_ref,
    output logic [1:0]                o_clk_lost,
    output logic                      o_scan_data_out,
    output logic                      o_reconfig_busy,
    output logic [CHAIN_LEN-1:0]      o_config
);
    // reference sense, one per input
    logic [1:0] ref_rise;
    logic [1:0] ref_fall;
    logic [1:0] ref_lost;

    ref_edge_sense u_sense_pri (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_ref  (i_ref_clock_primary),
        .o_rise (ref_rise[0]),
        .o_fall (ref_fall[0]),
        .o_lost (ref_lost[0])
    );

    ref_edge_sense u_sense_bak (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_ref  (i_ref_clock_backup),
        .o_rise (ref_rise[1]),
        .o_fall (ref_fall[1]),
        .o_lost (ref_lost[1])
    );

    // two-flop synchronisers for the control pins
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic       auto_s;
    logic       req_s;
    logic       scan_clk_s;
    logic       scan_data_s;
    logic       scan_ena_s;
    logic       apply_s;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= {i_auto_mode, i_apply, i_scan_ena, i_scan_data, i_scan_clk, i_switch_req};
            pin_sync <= pin_meta;
        end
    end

    // synchronised views of the control pins
    assign auto_s      = pin_sync[5];
    assign req_s       = pin_sync[0];
    assign scan_clk_s  = pin_sync[1];
    assign scan_data_s = pin_sync[2];
    assign scan_ena_s  = pin_sync[3];
    assign apply_s     = pin_sync[4];

    // switchover sequencer
    pll_ctl_pkg::sw_state_t state;
    pll_ctl_pkg::sw_state_t next_state;
    logic       req_prev;
    logic       next_req_prev;
    logic [1:0] hold_cnt;
    logic [1:0] next_hold_cnt;
    logic       sel;
    logic       next_sel;
    logic       gate;
    logic       next_gate;
    logic       target;
    logic       next_target;
    logic       req_rise;
    logic       cur_lost;

    assign req_rise = req_s & ~req_prev;
    assign cur_lost = ref_lost[sel];

    always_comb begin
        next_state    = state;
        next_req_prev = req_s;
        next_hold_cnt = hold_cnt;
        next_sel      = sel;
        next_gate     = gate;
        next_target   = target;
        case (state)
            pll_ctl_pkg::SW_IDLE: begin
                if (req_rise) begin
                    next_state    = pll_ctl_pkg::SW_HOLD;
                    next_hold_cnt = 2'h0;
                    next_target   = ~sel;
                end else if (auto_s && !req_s && cur_lost && !ref_lost[~sel]) begin
                    next_state  = pll_ctl_pkg::SW_GATE_OLD; // automatic switch on loss
                    next_target = ~sel;
                end
            end
            pll_ctl_pkg::SW_HOLD: begin
                // count rising edges of either reference while held high
                if (!req_s) begin
                    next_state = pll_ctl_pkg::SW_IDLE;
                end else if (ref_rise[0] || ref_rise[1]) begin
                    if (hold_cnt == 2'(HOLD_CYC - 1)) begin
                        next_state = pll_ctl_pkg::SW_GATE_OLD;
                    end else begin
                        next_hold_cnt = hold_cnt + 2'h1;
                    end
                end
            end
            pll_ctl_pkg::SW_GATE_OLD: begin
                // stop the counters' reference on the old input's falling edge
                if (ref_fall[sel] || ref_lost[sel]) begin
                    next_gate  = 1'b0;
                    next_state = pll_ctl_pkg::SW_WAIT_NEW;
                end
            end
            pll_ctl_pkg::SW_WAIT_NEW: begin
                // wait for the target to toggle, then move the mux on its fall
                if (ref_fall[target] && !ref_lost[target]) begin
                    next_sel   = target;
                    next_gate  = 1'b1;
                    next_state = pll_ctl_pkg::SW_IDLE;
                end
            end
            default: begin
                next_state = pll_ctl_pkg::SW_IDLE;
            end
        endcase
    end

    // register the switchover state
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state    <= pll_ctl_pkg::SW_IDLE;
            req_prev <= 1'b0;
            hold_cnt <= 2'h0;
            sel      <= pll_ctl_pkg::SEL_PRIMARY;
            gate     <= 1'b1;
            target   <= pll_ctl_pkg::SEL_PRIMARY;
        end else begin
            state    <= next_state;
            req_prev <= next_req_prev;
            hold_cnt <= next_hold_cnt;
            sel      <= next_sel;
            gate     <= next_gate;
            target   <= next_target;
        end
    end

    // status: loss flags only in automatic mode; manual switches keep them low
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_clk_lost <= 2'b00;
        end else if (auto_s) begin
            o_clk_lost <= ref_lost;
        end else begin
            o_clk_lost <= 2'b00;
        end
    end

    // selection outputs
    assign o_ref_mux_sel  = sel;
    assign o_ref_gate_ena = gate;
    assign o_active_ref   = sel;

    // scan chain and apply sequencer
    logic [CHAIN_LEN-1:0] chain;
    logic [CHAIN_LEN-1:0] next_chain;
    logic [CHAIN_LEN-1:0] pending;
    logic [CHAIN_LEN-1:0] next_pending;
    logic [CHAIN_LEN-1:0] upd_left;
    logic [CHAIN_LEN-1:0] next_upd_left;
    logic                 sclk_prev;
    logic                 sclk_rise;
    logic                 ena_q;
    logic                 next_ena_q;
    logic                 apply_prev;
    logic                 next_apply_prev;
    logic                 busy;
    logic                 next_busy;

    assign sclk_rise = scan_clk_s & ~sclk_prev;

    // shift on each shift-clock rise; enable is registered on a rise so the
    // first bit enters on the second rise after enable goes high
    always_comb begin
        next_chain    = chain;
        next_ena_q    = ena_q;
        next_pending  = pending;
        next_upd_left = upd_left;
        next_busy     = busy;
        next_apply_prev = busy ? 1'b1 : apply_s;
        if (sclk_rise) begin
            next_ena_q = scan_ena_s;
            if (ena_q && scan_ena_s) begin
                next_chain = {scan_data_s, chain[CHAIN_LEN-1:1]};
            end
        end
        // a dropped enable clears the lead-in, so a stopped clock cannot skip it
        if (!scan_ena_s) begin
            next_ena_q = 1'b0;
        end
        if (!busy && apply_s && !apply_prev && !scan_ena_s) begin
            next_pending  = chain;
            next_upd_left = {CHAIN_LEN{1'b1}};
            next_busy     = 1'b1;
        end else if (busy) begin
            // each counter bit lands on its own counter clock tick
            next_upd_left = upd_left & ~i_counter_clk_tick;
            if (upd_left == '0) begin
                next_busy = 1'b0;
            end
        end
    end

    // per-bit configuration update on the owning counter's tick
    genvar gi;
    generate
        for (gi = 0; gi < CHAIN_LEN; gi++) begin : g_cfg
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    o_config[gi] <= 1'b0;
                end else if (busy && upd_left[gi] && i_counter_clk_tick[gi]) begin
                    o_config[gi] <= pending[gi];
                end
            end
        end
    endgenerate

    // register the chain and apply state
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            chain      <= '0;
            pending    <= '0;
            upd_left   <= '0;
            sclk_prev  <= 1'b0;
            ena_q      <= 1'b0;
            apply_prev <= 1'b0;
            busy       <= 1'b0;
        end else begin
            chain      <= next_chain;
            pending    <= next_pending;
            upd_left   <= next_upd_left;
            sclk_prev  <= scan_clk_s;
            ena_q      <= next_ena_q;
            apply_prev <= next_apply_prev;
            busy       <= next_busy;
        end
    end

    // serial tap and busy status
    assign o_scan_data_out = chain[0];
    assign o_reconfig_busy = busy;
endmodule // pll_switchover_and_reconfig

// ---- testbench/pll_ctl_monitor.sv ----
/*
 * Port checker for the switchover and reconfiguration controller.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
module pll_ctl_monitor #(
    parameter int CHAIN_LEN = pll_ctl_pkg::CHAIN_LEN_TEN
) (
    input wire logic                 i_mclk,
    input wire logic                 i_rst,
    input wire logic                 i_auto_mode,
    input wire logic                 i_scan_ena,
    input wire logic                 i_apply,
    input wire logic [CHAIN_LEN-1:0] i_counter_clk_tick,
    input wire logic                 o_ref_mux_sel,
    input wire logic                 o_ref_gate_ena,
    input wire logic                 o_active_ref,
    input wire logic [1:0]           o_clk_lost,
    input wire logic                 o_scan_data_out,
    input wire logic                 o_reconfig_busy,
    input wire logic [CHAIN_LEN-1:0] o_config
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // status and selection relations
    sel_tracks_a: assert property (o_active_ref == o_ref_mux_sel && (!$changed(o_active_ref) || o_ref_gate_ena))
        else $error("active indicator differs from mux select");
    lost_manual_a: assert property (!$past(i_auto_mode, 3) |-> o_clk_lost == 2'h0)
        else $error("loss flag raised in manual mode");
    sel_gated_a: assert property (o_ref_mux_sel != $past(o_ref_mux_sel) |-> !$past(o_ref_gate_ena))
        else $error("select moved while gate open");
    // reconfiguration relations
    busy_start_a: assert property ($rose(i_apply) && !o_reconfig_busy && !i_scan_ena |-> ##[1:6] o_reconfig_busy)
        else $error("apply did not raise busy");
    busy_bound_a: assert property ($rose(o_reconfig_busy) |-> ##[1:60] !o_reconfig_busy)
        else $error("busy never fell");
    cfg_hold_a: assert property (!o_reconfig_busy && !$past(o_reconfig_busy) |-> $stable(o_config))
        else $error("settings changed while idle");
    tick_update_a: assert property (((o_config ^ $past(o_config)) & ~($past(i_counter_clk_tick)
        | $past(i_counter_clk_tick, 2))) == '0)
        else $error("setting bit changed without its tick");
    scan_hold_a: assert property ((!i_scan_ena)[*4] |=> $stable(o_scan_data_out))
        else $error("chain moved with shift disabled");
endmodule // pll_ctl_monitor

// ---- testbench/scan_feeder.sv ----
/*
 * Behavioural controller on the scan side: shift clock, enable, data, apply.
 * Assumes the block samples these pins with its own 40 MHz clock.
 */
`timescale 1ns/1ps
module scan_feeder #(
    parameter int N = 16
) (
    output logic o_clk,
    output logic o_ena,
    output logic o_data,
    output logic o_apply
);
    initial begin
        o_clk = 1'b0;
        o_ena = 1'b0;
        o_data = 1'b0;
        o_apply = 1'b0;
    end
    // enable one rise ahead, first bit is v[0], exactly N shifts, 200 ns clock
    task automatic load(input logic [N-1:0] v);
        o_ena = 1'b1;
        for (int k = 0; k <= N; k++) begin
            o_data = v[(k == 0) ? 0 : k - 1];
            #100 o_clk = 1'b1;
            #100 o_clk = 1'b0;
        end
        o_ena = 1'b0;
        o_data = ~o_data; // released line no longer shows the last bit
    endtask
    // apply held for one full shift-clock period, clock stands still
    task automatic apply();
        #100 o_apply = 1'b1;
        #200 o_apply = 1'b0;
    endtask
endmodule // scan_feeder

// ---- testbench/pll_switchover_and_reconfig_bench.sv ----
/*
 * Self-checking bench: manual and automatic switchover, scan load and apply.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/1ps
module pll_switchover_and_reconfig_bench;
    localparam int CL = 16;
    logic          i_mclk, i_rst, ref_p, ref_b, run_p, run_b, i_switch_req, i_auto_mode;
    logic          scan_clk, scan_ena, scan_data, apply_in, o_ref_mux_sel, o_ref_gate_ena;
    logic          o_active_ref, o_scan_data_out, o_reconfig_busy, prev_sel, prev_busy;
    logic [CL-1:0] tick, o_config, v;
    logic [1:0]    o_clk_lost;
    logic [31:0]   seed;
    int            n_mismatch, num_checks;
    logic          sel_q[$];
    logic [CL-1:0] cfg_q[$];

    pll_switchover_and_reconfig #(.CHAIN_LEN(CL)) dut (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_ref_clock_primary(ref_p), .i_ref_clock_backup(ref_b),
        .i_switch_req(i_switch_req), .i_auto_mode(i_auto_mode), .i_scan_clk(scan_clk),
        .i_scan_data(scan_data), .i_scan_ena(scan_ena), .i_apply(apply_in),
        .i_counter_clk_tick(tick), .o_ref_mux_sel(o_ref_mux_sel), .o_ref_gate_ena(o_ref_gate_ena),
        .o_active_ref(o_active_ref), .o_clk_lost(o_clk_lost), .o_scan_data_out(o_scan_data_out),
        .o_reconfig_busy(o_reconfig_busy), .o_config(o_config));
    scan_feeder #(.N(CL)) feed (.o_clk(scan_clk), .o_ena(scan_ena), .o_data(scan_data), .o_apply(apply_in));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wait_sel();
        for (int i = 0; i < 800 && sel_q.size() > 0; i++) cyc(1);
        chk("switch done", sel_q.size(), 0);
        chk("gate reopened", o_ref_gate_ena, 1);
    endtask

    // clocks: system 25 ns, references 400 ns and 500 ns, stoppable
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    always #200 if (run_p) ref_p = ~ref_p;
    always #250 if (run_b) ref_b = ~ref_b;
    // staggered per-counter ticks from the random stream
    always @(posedge i_mclk) begin
        #1 tick = CL'(rnd());
    end
    // watcher: each selection change and each end of busy takes the oldest note
    always @(posedge i_mclk) begin
        if (!i_rst && o_active_ref !== prev_sel) begin
            if (sel_q.size() == 0) chk("unexpected switch", o_active_ref, prev_sel);
            else chk("active ref", o_active_ref, sel_q.pop_front());
        end
        if (!i_rst && prev_busy === 1'b1 && o_reconfig_busy === 1'b0) begin
            if (cfg_q.size() == 0) chk("unexpected update", 1, 0);
            else chk("config", o_config, cfg_q.pop_front());
        end
        prev_sel = o_active_ref;
        prev_busy = o_reconfig_busy;
    end
    initial begin
        #2_000_000;
        n_mismatch++;
        close_out();
    end

    initial begin
        seed = 32'hC6A6B36C;
        {i_rst, ref_p, ref_b, run_p, run_b, i_switch_req, i_auto_mode, tick} = {7'h4C, {CL{1'b0}}};
        prev_sel = 1'b0;
        prev_busy = 1'b0;
        cyc(4);
        i_rst = 1'b0;
        cyc(4);
        chk("sel after reset", o_active_ref, pll_ctl_pkg::SEL_PRIMARY);
        chk("busy after reset", o_reconfig_busy, 0);
        // manual: target stopped, so the switch waits for it
        i_switch_req = 1'b1;
        cyc(10);
        run_b = 1'b0;
        cyc(150);
        sel_q.push_back(pll_ctl_pkg::SEL_BACKUP);
        run_b = 1'b1;
        wait_sel();
        i_switch_req = 1'b0;
        cyc(100);
        // short pulse holds fewer than three reference edges: no switch
        i_switch_req = 1'b1;
        cyc(2);
        i_switch_req = 1'b0;
        cyc(150);
        i_switch_req = 1'b1;
        sel_q.push_back(pll_ctl_pkg::SEL_PRIMARY);
        wait_sel();
        cyc(60);
        chk("loss flags manual", o_clk_lost, 2'h0);
        i_switch_req = 1'b0;
        // automatic: primary stops, flag rises and backup takes over
        i_auto_mode = 1'b1;
        cyc(20);
        run_p = 1'b0;
        sel_q.push_back(pll_ctl_pkg::SEL_BACKUP);
        for (int i = 0; i < 400 && o_clk_lost[0] !== 1'b1; i++) cyc(1);
        chk("primary lost", o_clk_lost[0], 1);
        wait_sel();
        chk("backup present", o_clk_lost[1], 0);
        run_p = 1'b1;
        cyc(100);
        // scan loads with random settings, chain out shows first bit
        for (int n = 0; n < 2; n++) begin
            v = CL'(rnd());
            feed.load(v);
            cyc(4);
            chk("chain out", o_scan_data_out, v[0]);
            cfg_q.push_back(v);
            feed.apply();
            for (int i = 0; i < 200 && cfg_q.size() > 0; i++) cyc(1);
            chk("update done", cfg_q.size(), 0);
        end
        close_out();
    end
endmodule // pll_switchover_and_reconfig_bench

bind pll_switchover_and_reconfig pll_ctl_monitor #(.CHAIN_LEN(CHAIN_LEN)) mon (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_auto_mode(i_auto_mode), .i_scan_ena(i_scan_ena),
    .i_apply(i_apply), .i_counter_clk_tick(i_counter_clk_tick), .o_ref_mux_sel(o_ref_mux_sel),
    .o_ref_gate_ena(o_ref_gate_ena), .o_active_ref(o_active_ref), .o_clk_lost(o_clk_lost),
    .o_scan_data_out(o_scan_data_out), .o_reconfig_busy(o_reconfig_busy), .o_config(o_config));
